// ---- include/lert_pkg.sv ----
package lert_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the bus.
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00; // Configuration.
  localparam logic [7:0] CMD_OFS    = 8'h04; // Commands, write only.
  localparam logic [7:0] STATUS_OFS = 8'h08; // Running state.
  localparam logic [7:0] CNT_OFS    = 8'h0c; // Counter, read only.
  localparam logic [7:0] FIRST_COMPARE_VALUE_OFS  = 8'h10; // First compare value.
  localparam logic [7:0] SECOND_COMPARE_VALUE_OFS  = 8'h14; // Second compare value.
  localparam logic [7:0] PRIMARY_REPEAT_DONE_FLAG_OFS   = 8'h18; // Primary repeat count.
  localparam logic [7:0] SECONDARY_REPEAT_DONE_FLAG_OFS   = 8'h1c; // Secondary repeat count.
  localparam logic [7:0] IF_OFS     = 8'h20; // Interrupt flags.
  localparam logic [7:0] IFC_OFS    = 8'h24; // Flag clear, write 1.
  localparam logic [7:0] IEN_OFS    = 8'h28; // Interrupt enables.

  // ----------------------------------------------------------------
  // Field positions, widths and fixed values.
  // ----------------------------------------------------------------
  localparam int          CMD_START  = 0;  // Start command bit.
  localparam int          CMD_STOP   = 1;  // Stop command bit.
  localparam int          CMD_CLEAR  = 2;  // Clear command bit.
  localparam int          CTRL_W     = 13; // Width of the control word.
  localparam int          FLAG_W     = 5;  // Width of the flag word.
  localparam logic [15:0] CNT_WRAP   = 16'hffff; // Wrap value.
  localparam int          SYNC_LEN   = 2;  // Debug halt sync depth.

  // Repeat modes.
  localparam logic [1:0] REP_FREE = 2'h0;
  localparam logic [1:0] REP_ONE  = 2'h1;
  localparam logic [1:0] REP_BUF  = 2'h2;
  localparam logic [1:0] REP_DBL  = 2'h3;

  // Output action codes.
  localparam logic [1:0] OA_IDLE   = 2'h0;
  localparam logic [1:0] OA_TOGGLE = 2'h1;
  localparam logic [1:0] OA_PULSE  = 2'h2;
  localparam logic [1:0] OA_PWM    = 2'h3;

  // Control word, bit 0 is run_while_halted.
  typedef struct packed {
    logic       rtc_channel1_trigger_enable; // Bit 12.
    logic       rtc_channel0_trigger_enable; // Bit 11.
    logic       buffered_top_select;         // Bit 10.
    logic       top_from_compare_select;     // Bit 9.
    logic       output1_polarity;            // Bit 8.
    logic       output0_polarity;            // Bit 7.
    logic [1:0] output1_action_select;       // Bits 6:5.
    logic [1:0] output0_action_select;       // Bits 4:3.
    logic [1:0] repeat_mode_select;          // Bits 2:1.
    logic       run_while_halted;            // Bit 0.
  } ctrl_t;

  // Interrupt flag word, bit 0 is underflow.
  typedef struct packed {
    logic secondary_repeat_done_flag; // Bit 4.
    logic primary_repeat_done_flag;   // Bit 3.
    logic second_compare_value;                      // Bit 2.
    logic first_compare_value;                      // Bit 1.
    logic uf;                         // Bit 0.
  } flag_t;

endpackage

// ---- hw/low_energy_repeat_timer.sv ----
`timescale 1ns/1ps
module low_energy_repeat_timer (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Classic Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Compare events and debug state.
  input  wire logic        rtc_first_compare_value_i,
  input  wire logic        rtc_second_compare_value_i,
  input  wire logic        debug_halt_i,
  // Waveform outputs, status and request.
  output logic             out0_o,
  output logic             out1_o,
  output logic             running_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  lert_pkg::ctrl_t ctrl_r;          // Control word.
  lert_pkg::flag_t if_r;            // Sticky flags.
  lert_pkg::flag_t ien_r;           // Flag enables.
  logic [15:0]     cnt_r;           // Down counter.
  logic [15:0]     first_compare_value_r;         // First compare value.
  logic [15:0]     second_compare_value_r;         // Second compare value.
  logic [7:0]      primary_repeat_done_flag_r;          // Primary repeat count.
  logic [7:0]      secondary_repeat_done_flag_r;          // Secondary repeat count.
  logic            used_r;          // Secondary value consumed.
  logic            skip_r;          // Next wrap is silent.
  logic            run_r;           // Timer running.
  logic            act0_r;          // Output 0 active.
  logic            act1_r;          // Output 1 active.
  logic [1:0]      halt_sync_r;     // Debug halt synchroniser.
  logic            wr_v_r;          // Staged write valid.
  logic [7:0]      wr_a_r;          // Staged write address.
  logic [31:0]     wr_d_r;          // Staged write data.
  logic [3:0]      wr_s_r;          // Staged byte enables.

  // ----------------------------------------------------------------
  // Next values.
  // ----------------------------------------------------------------
  logic [15:0] cnt_nxt;
  logic [15:0] first_compare_value_nxt;
  logic [7:0]  primary_repeat_done_flag_nxt;
  logic [7:0]  secondary_repeat_done_flag_nxt;
  logic        used_nxt;
  logic        skip_nxt;
  logic        run_nxt;
  logic        act0_nxt;
  logic        act1_nxt;
  lert_pkg::flag_t set_ev;          // Flag set events.
  logic        ufev;                // Real underflow this cycle.
  logic        rstop;               // Repeat logic asks to stop.
  logic        cnt_en;              // Counting this cycle.
  logic        m1;                  // Second compare match.

  // Decoded staged commands.
  logic wr_cmd;
  logic start_ev;
  logic stop_cmd;
  logic clr_cmd;
  logic wr_primary_repeat_done_flag;
  logic wr_secondary_repeat_done_flag;
  logic [31:0] wdat;                // Staged data with lanes merged.
  logic [31:0] rdat;                // Read mux.

  // ----------------------------------------------------------------
  // Bus slave.
  // ----------------------------------------------------------------
  // A request is answered one cycle after it is seen; the ack stays
  // low for a cycle after each answer so one request gives one ack.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= rdat;
    end
  end

  // Writes are captured at the ack edge and applied a cycle later,
  // standing in for the crossing into the slow timer domain.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_v_r <= 1'b0;
      wr_a_r <= 8'h0;
      wr_d_r <= 32'h0;
      wr_s_r <= 4'h0;
    end
    else
    begin
      wr_v_r <= wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i;
      wr_a_r <= wb_adr_i;
      wr_d_r <= wb_dat_i;
      wr_s_r <= wb_sel_i;
    end
  end

  // Read mux; unmapped offsets read as zero.
  always_comb
  begin
    rdat = 32'h0;
    unique case (wb_adr_i)
      lert_pkg::CTRL_OFS:   rdat[12:0] = ctrl_r;
      lert_pkg::STATUS_OFS: rdat[0]    = run_r;
      lert_pkg::CNT_OFS:    rdat[15:0] = cnt_r;
      lert_pkg::FIRST_COMPARE_VALUE_OFS:  rdat[15:0] = first_compare_value_r;
      lert_pkg::SECOND_COMPARE_VALUE_OFS:  rdat[15:0] = second_compare_value_r;
      lert_pkg::PRIMARY_REPEAT_DONE_FLAG_OFS:   rdat[7:0]  = primary_repeat_done_flag_r;
      lert_pkg::SECONDARY_REPEAT_DONE_FLAG_OFS:   rdat[7:0]  = secondary_repeat_done_flag_r;
      lert_pkg::IF_OFS:     rdat[4:0]  = if_r;
      lert_pkg::IEN_OFS:    rdat[4:0]  = ien_r;
      default:              rdat       = 32'h0;
    endcase
  end

  // Byte lanes not selected keep zero; registers are written whole.
  always_comb
  begin
    wdat = 32'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (wr_s_r[i])
      begin
        wdat[8*i +: 8] = wr_d_r[8*i +: 8];
      end
    end
  end

  // Command and trigger decode; stop beats start.
  always_comb
  begin
    wr_cmd   = wr_v_r & (wr_a_r == lert_pkg::CMD_OFS);
    stop_cmd = wr_cmd & wdat[lert_pkg::CMD_STOP];
    clr_cmd  = wr_cmd & wdat[lert_pkg::CMD_CLEAR];
    // Compare events start the timer when enabled.
    start_ev = (wr_cmd & wdat[lert_pkg::CMD_START])
             | (rtc_first_compare_value_i & ctrl_r.rtc_channel0_trigger_enable)
             | (rtc_second_compare_value_i & ctrl_r.rtc_channel1_trigger_enable);
    wr_primary_repeat_done_flag  = wr_v_r & (wr_a_r == lert_pkg::PRIMARY_REPEAT_DONE_FLAG_OFS);
    wr_secondary_repeat_done_flag  = wr_v_r & (wr_a_r == lert_pkg::SECONDARY_REPEAT_DONE_FLAG_OFS);
  end

  // ----------------------------------------------------------------
  // Debug pause.
  // ----------------------------------------------------------------
  // Two flops give the documented two-cycle lag each way.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      halt_sync_r <= 2'h0;
    end
    else
    begin
      halt_sync_r <= {halt_sync_r[0], debug_halt_i};
    end
  end

  // The pause only gates counting; run_r is untouched.
  assign cnt_en = run_r & ~(halt_sync_r[1] & ~ctrl_r.run_while_halted);

  // ----------------------------------------------------------------
  // Counter and repeat logic.
  // ----------------------------------------------------------------
  always_comb
  begin
    cnt_nxt   = cnt_r;
    first_compare_value_nxt = first_compare_value_r;
    primary_repeat_done_flag_nxt  = primary_repeat_done_flag_r;
    secondary_repeat_done_flag_nxt  = secondary_repeat_done_flag_r;
    used_nxt  = used_r;
    skip_nxt  = skip_r;
    set_ev    = '0;
    ufev      = 1'b0;
    rstop     = 1'b0;
    m1        = cnt_en & (cnt_r == second_compare_value_r);
    if (cnt_en)
    begin
      set_ev.first_compare_value = (cnt_r == first_compare_value_r);
      set_ev.second_compare_value = m1;
      if (cnt_r == 16'h0)
      begin
        // Reload from the top value or wrap.
        cnt_nxt = ctrl_r.top_from_compare_select ? first_compare_value_r : lert_pkg::CNT_WRAP;
        ufev    = ~skip_r; // Wrap after a clear is silent.
        skip_nxt = 1'b0;
      end
      else
      begin
        cnt_nxt = cnt_r - 16'h1;
      end
    end
    set_ev.uf = ufev;
    if (ufev)
    begin
      unique case (ctrl_r.repeat_mode_select)
        lert_pkg::REP_FREE: ; // Repeat counters ignored.
        lert_pkg::REP_ONE:
        begin
          // Decrement, stop on reaching zero.
          if (primary_repeat_done_flag_r != 8'h0)
          begin
            primary_repeat_done_flag_nxt = primary_repeat_done_flag_r - 8'h1;
          end
          set_ev.primary_repeat_done_flag = (primary_repeat_done_flag_r == 8'h1);
          rstop = (primary_repeat_done_flag_r <= 8'h1);
        end
        lert_pkg::REP_BUF:
        begin
          if ((primary_repeat_done_flag_r == 8'h1) && (secondary_repeat_done_flag_r != 8'h0) && !used_r)
          begin
            // Transfer the fresh secondary value.
            primary_repeat_done_flag_nxt = secondary_repeat_done_flag_r;
            used_nxt = 1'b1;
            set_ev.primary_repeat_done_flag = 1'b1;
            if (ctrl_r.buffered_top_select)
            begin
              first_compare_value_nxt = second_compare_value_r;
            end
          end
          else
          begin
            if (primary_repeat_done_flag_r != 8'h0)
            begin
              primary_repeat_done_flag_nxt = primary_repeat_done_flag_r - 8'h1;
            end
            set_ev.primary_repeat_done_flag = (primary_repeat_done_flag_r == 8'h1);
            rstop = (primary_repeat_done_flag_r <= 8'h1);
          end
        end
        lert_pkg::REP_DBL:
        begin
          // Each counts down alone and rests at zero.
          if (primary_repeat_done_flag_r != 8'h0)
          begin
            primary_repeat_done_flag_nxt = primary_repeat_done_flag_r - 8'h1;
          end
          if (secondary_repeat_done_flag_r != 8'h0)
          begin
            secondary_repeat_done_flag_nxt = secondary_repeat_done_flag_r - 8'h1;
          end
          set_ev.primary_repeat_done_flag   = (primary_repeat_done_flag_r == 8'h1);
          set_ev.secondary_repeat_done_flag = (secondary_repeat_done_flag_r == 8'h1);
          rstop = (primary_repeat_done_flag_r <= 8'h1) && (secondary_repeat_done_flag_r <= 8'h1);
        end
      endcase
    end
    // A buffered start from an empty state loads the secondary.
    if (start_ev && !run_r && (ctrl_r.repeat_mode_select == lert_pkg::REP_BUF)
        && (cnt_r == 16'h0) && (primary_repeat_done_flag_r == 8'h0) && (secondary_repeat_done_flag_r != 8'h0) && !used_r)
    begin
      primary_repeat_done_flag_nxt = secondary_repeat_done_flag_r;
      used_nxt = 1'b1;
      set_ev.primary_repeat_done_flag = 1'b1;
    end
    // Clear overrides every other counter update.
    if (clr_cmd)
    begin
      cnt_nxt  = 16'h0;
      skip_nxt = 1'b1;
    end
    // Software writes win over decrements and loads.
    if (wr_primary_repeat_done_flag)
    begin
      primary_repeat_done_flag_nxt = wdat[7:0];
    end
    if (wr_secondary_repeat_done_flag)
    begin
      secondary_repeat_done_flag_nxt = wdat[7:0];
      used_nxt = 1'b0; // Rearm the secondary value.
    end
    if (wr_v_r && (wr_a_r == lert_pkg::FIRST_COMPARE_VALUE_OFS))
    begin
      first_compare_value_nxt = wdat[15:0];
    end
    // A fresh repeat write keeps the timer going.
    if (wr_primary_repeat_done_flag || wr_secondary_repeat_done_flag)
    begin
      rstop = 1'b0;
    end
    // Stop wins, then start, then repeat exhaustion.
    if (stop_cmd)
    begin
      run_nxt = 1'b0;
    end
    else if (start_ev)
    begin
      run_nxt = 1'b1;
    end
    else
    begin
      run_nxt = run_r & ~rstop;
    end
  end

  // Counter, repeat and run state.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r   <= 16'h0;
      first_compare_value_r <= 16'h0;
      primary_repeat_done_flag_r  <= 8'h0;
      secondary_repeat_done_flag_r  <= 8'h0;
      used_r  <= 1'b0;
      skip_r  <= 1'b0;
      run_r   <= 1'b0;
    end
    else
    begin
      cnt_r   <= cnt_nxt;
      first_compare_value_r <= first_compare_value_nxt;
      primary_repeat_done_flag_r  <= primary_repeat_done_flag_nxt;
      secondary_repeat_done_flag_r  <= secondary_repeat_done_flag_nxt;
      used_r  <= used_nxt;
      skip_r  <= skip_nxt;
      run_r   <= run_nxt;
    end
  end

  // Configuration registers.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r  <= '0;
      second_compare_value_r <= 16'h0;
      ien_r   <= '0;
    end
    else if (wr_v_r)
    begin
      if (wr_a_r == lert_pkg::CTRL_OFS)
      begin
        ctrl_r <= wdat[12:0];
      end
      if (wr_a_r == lert_pkg::SECOND_COMPARE_VALUE_OFS)
      begin
        second_compare_value_r <= wdat[15:0];
      end
      if (wr_a_r == lert_pkg::IEN_OFS)
      begin
        ien_r <= wdat[4:0];
      end
    end
  end

  // Sticky flags; a set in the clearing cycle wins.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      if_r  <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      if (wr_v_r && (wr_a_r == lert_pkg::IFC_OFS))
      begin
        if_r <= (if_r & ~wdat[4:0]) | set_ev;
      end
      else
      begin
        if_r <= if_r | set_ev;
      end
      irq_o <= |(if_r & ien_r);
    end
  end

  // ----------------------------------------------------------------
  // Output actions.
  // ----------------------------------------------------------------
  // Next active state of one output from its action code. PWM and
  // pulse return idle whatever the count; activation needs it.
  function automatic logic act_f(input logic [1:0] oa, input logic act,
                                 input logic uf, input logic match,
                                 input logic nz);
    logic r;
    r = act;
    unique case (oa)
      lert_pkg::OA_IDLE:   r = 1'b0;
      lert_pkg::OA_TOGGLE: r = (uf & nz) ? ~act : act;
      lert_pkg::OA_PULSE:  r = uf & nz;
      lert_pkg::OA_PWM:    r = uf ? 1'b0 : ((match & nz) ? 1'b1 : act);
    endcase
    return r;
  endfunction

  assign act0_nxt = act_f(ctrl_r.output0_action_select, act0_r, ufev, m1,
                          primary_repeat_done_flag_r != 8'h0);
  assign act1_nxt = act_f(ctrl_r.output1_action_select, act1_r, ufev, m1,
                          secondary_repeat_done_flag_r != 8'h0);

  // Pins are registered; polarity flips idle and active.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      act0_r    <= 1'b0;
      act1_r    <= 1'b0;
      out0_o    <= 1'b0;
      out1_o    <= 1'b0;
      running_o <= 1'b0;
    end
    else
    begin
      act0_r    <= act0_nxt;
      act1_r    <= act1_nxt;
      out0_o    <= act0_nxt ^ ctrl_r.output0_polarity;
      out1_o    <= act1_nxt ^ ctrl_r.output1_polarity;
      running_o <= run_nxt; // Pause leaves the status set.
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_stop_over_start: assert property (stop_cmd |=> !run_r)
    else $error("stop did not win");
  a_clear_zero: assert property (clr_cmd |=> cnt_r == 16'h0 && skip_r)
    else $error("clear did not zero counter");
  a_silent_wrap: assert property (skip_r && cnt_en && cnt_r == 16'h0 |=>
    !if_r.uf || $past(if_r.uf))
    else $error("underflow raised after clear");
  a_oneshot_end: assert property (cnt_en && !skip_r && cnt_r == 16'h0
    && ctrl_r.repeat_mode_select == lert_pkg::REP_ONE && primary_repeat_done_flag_r == 8'h1
    && !wr_v_r && !start_ev |=> !run_r && primary_repeat_done_flag_r == 8'h0 && if_r.primary_repeat_done_flag)
    else $error("one-shot did not stop");
  a_primary_repeat_done_flag_write: assert property (wr_primary_repeat_done_flag |=> primary_repeat_done_flag_r == $past(wdat[7:0]))
    else $error("primary write lost");
  a_free_runs: assert property (run_r && !stop_cmd
    && ctrl_r.repeat_mode_select == lert_pkg::REP_FREE |=> run_r)
    else $error("free mode stopped");
  a_buf_transfer: assert property (ufev && !wr_v_r
    && ctrl_r.repeat_mode_select == lert_pkg::REP_BUF && primary_repeat_done_flag_r == 8'h1
    && secondary_repeat_done_flag_r != 8'h0 && !used_r |=> primary_repeat_done_flag_r == $past(secondary_repeat_done_flag_r) && used_r
    && if_r.primary_repeat_done_flag)
    else $error("buffered transfer missing");
  a_rtc_start: assert property (rtc_first_compare_value_i && ctrl_r.rtc_channel0_trigger_enable
    && !stop_cmd |=> run_r ##1 running_o)
    else $error("compare event did not start");
  a_debug_pause: assert property (debug_halt_i [*3] ##0 !ctrl_r.run_while_halted
    && !wr_v_r |=> $stable(cnt_r))
    else $error("counter moved while halted");
  // The pin shows the polarity that stood when it was launched, so a
  // control write in the same cycle must not be held against it.
  a_idle_level: assert property (ctrl_r.output0_action_select == lert_pkg::OA_IDLE
    && $stable(ctrl_r) |=> out0_o == $past(ctrl_r.output0_polarity))
    else $error("output 0 not idle");
  a_irq_level: assert property (|(if_r & ien_r) |=> irq_o)
    else $error("request missing");

endmodule

// ---- verif/rtc_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Compare-event source standing in for the real-time counter.
// ------------------------------------------------------------
module rtc_model (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Bench request, one bit per compare channel.
  input  wire logic [1:0] fire_i,
  // Compare events towards the timer.
  output logic            first_compare_value_o,
  output logic            second_compare_value_o
);
  // Each event lasts one timer clock, so the timer clock is never slower
  // than the event source and one match gives a single trigger.
  always @(posedge clk_i)
  begin
    first_compare_value_o <= !rst_i && fire_i[0];
    second_compare_value_o <= !rst_i && fire_i[1];
  end
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
  // ------------------------------------------------------------
  // Stimulus, observed outputs and bookkeeping.
  // ------------------------------------------------------------
  logic        clk_i = 1'b0, rst_i = 1'b1, dbg = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hf;
  logic [31:0] dat = 32'h0, rdat, last, seed = 32'h0000ef19;
  logic [1:0]  fire = 2'h0;
  logic        ack, o0, o1, run, irq, c0, c1, p0, p1;
  logic [31:0] q[$];
  int          fails = 0, checks_done = 0, e0 = 0, e1 = 0;
  lert_pkg::ctrl_t c;

  always #50 clk_i = ~clk_i;

  low_energy_repeat_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .rtc_first_compare_value_i(c0),
    .rtc_second_compare_value_i(c1), .debug_halt_i(dbg), .out0_o(o0), .out1_o(o1),
    .running_o(run), .irq_o(irq));
  rtc_model rtc (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
    .first_compare_value_o(c0), .second_compare_value_o(c1));

  task automatic finish_test;
    if (fails == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Read data is judged here, oldest note first.
  always @(posedge clk_i)
    if (ack === 1'b1 && we === 1'b0 && q.size() > 0)
      chk("read data", q.pop_front(), rdat);

  // Output edges are counted to see how many actions were applied.
  always @(posedge clk_i)
  begin
    if (o0 !== p0) e0++;
    if (o1 !== p1) e1++;
    p0 <= o0;
    p1 <= o1;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Classic single cycle: held until ack is sampled, then released.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fails++;
      finish_test();
    end
    last = rdat;
    {cyc, stb} <= 2'b00;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask

  task automatic cw(input lert_pkg::ctrl_t v);
    wb(1'b1, lert_pkg::CTRL_OFS, {19'h0, v});
  endtask

  task automatic cmd(input int b);
    wb(1'b1, lert_pkg::CMD_OFS, 32'h1 << b);
  endtask

  // Bounded wait for the running status to reach a level.
  task automatic wt(input logic v);
    int n;
    n = 0;
    while (run !== v && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 300)
    begin
      fails++;
      finish_test();
    end
  endtask

  // One repeat-mode run, top three; oa holds output 1's action code
  // above output 0's, and x0 and x1 count the pin edges expected.
  task automatic rm(input logic [1:0] m, input logic [7:0] r0, input logic [7:0] r1,
                    input int x0, input int x1, input logic [31:0] xf,
                    input logic [3:0] oa);
    c = '0;
    c.repeat_mode_select = m;
    c.top_from_compare_select = 1'b1;
    c.output0_action_select = oa[1:0];
    c.output1_action_select = oa[3:2];
    cw(c);
    wb(1'b1, lert_pkg::IFC_OFS, 32'h1f);
    wb(1'b1, lert_pkg::FIRST_COMPARE_VALUE_OFS, 32'h3);
    wb(1'b1, lert_pkg::SECOND_COMPARE_VALUE_OFS, 32'h2);
    wb(1'b1, lert_pkg::PRIMARY_REPEAT_DONE_FLAG_OFS, {24'h0, r0});
    wb(1'b1, lert_pkg::SECONDARY_REPEAT_DONE_FLAG_OFS, {24'h0, r1});
    cmd(lert_pkg::CMD_CLEAR);
    e0 = 0;
    e1 = 0;
    cmd(lert_pkg::CMD_START);
    wt(1'b1);
    wt(1'b0);
    repeat (3) @(posedge clk_i);
    chk("out0 actions", x0, e0);
    chk("out1 actions", x1, e1);
    rd(lert_pkg::IF_OFS, xf);
  endtask

  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(lert_pkg::STATUS_OFS, 32'h0);
    rd(lert_pkg::CNT_OFS, 32'h0);
    rd(8'h3c, 32'h0);
    seed = xs(seed);
    wb(1'b1, lert_pkg::SECOND_COMPARE_VALUE_OFS, {16'h0, seed[15:0]});
    rd(lert_pkg::SECOND_COMPARE_VALUE_OFS, {16'h0, seed[15:0]});
    c = '0;
    c.output0_polarity = 1'b1;
    cw(c);
    repeat (3) @(posedge clk_i);
    chk("out0 idle", 32'h1, {31'h0, o0});
    chk("out1 idle", 32'h0, {31'h0, o1});
    rm(lert_pkg::REP_ONE, 8'h2, 8'h0, 2, 0, 32'h0f, 4'h5);
    wb(1'b1, lert_pkg::IEN_OFS, 32'h08);
    repeat (3) @(posedge clk_i);
    chk("irq set", 32'h1, {31'h0, irq});
    wb(1'b1, lert_pkg::IFC_OFS, 32'h08);
    repeat (3) @(posedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rm(lert_pkg::REP_BUF, 8'h0, 8'h2, 2, 2, 32'h0f, 4'h5);
    // Transfer in mid-run, then the consumed value is not taken again.
    rm(lert_pkg::REP_BUF, 8'h1, 8'h2, 3, 3, 32'h0f, 4'h5);
    rm(lert_pkg::REP_DBL, 8'h1, 8'h3, 1, 3, 32'h1f, 4'h5);
    // PWM on output 0 and pulse on output 1, each gated by its count.
    rm(lert_pkg::REP_DBL, 8'h1, 8'h2, 2, 4, 32'h1f, 4'hb);
    c = '0;
    cw(c);
    cmd(lert_pkg::CMD_START);
    wt(1'b1);
    @(posedge clk_i);
    dbg <= 1'b1;
    repeat (6) @(posedge clk_i);
    wb(1'b0, lert_pkg::CNT_OFS, 32'h0);
    seed = last;
    repeat (4) @(posedge clk_i);
    wb(1'b0, lert_pkg::CNT_OFS, 32'h0);
    chk("count frozen", seed, last);
    chk("running kept", 32'h1, {31'h0, run});
    c.run_while_halted = 1'b1;
    cw(c);
    wb(1'b0, lert_pkg::CNT_OFS, 32'h0);
    seed = last;
    repeat (4) @(posedge clk_i);
    wb(1'b0, lert_pkg::CNT_OFS, 32'h0);
    chk("count moves", 32'h1, {31'h0, seed !== last});
    dbg <= 1'b0;
    wb(1'b1, lert_pkg::CMD_OFS, 32'h3);
    wt(1'b0);
    rd(lert_pkg::STATUS_OFS, 32'h0);
    for (int ch = 0; ch < 2; ch++)
    begin
      c = '0;
      c.rtc_channel0_trigger_enable = (ch == 0);
      c.rtc_channel1_trigger_enable = (ch == 1);
      cw(c);
      @(posedge clk_i);
      fire <= 2'h1 << ch;
      @(posedge clk_i);
      fire <= 2'h0;
      wt(1'b1);
      cmd(lert_pkg::CMD_STOP);
      wt(1'b0);
    end
    repeat (4) @(posedge clk_i);
    finish_test();
  end
endmodule
